// File: rtl/mtb_tx.v
// Behaviour
// RL1: Transmit FIFO holds 80 entries of a data byte plus parity bit.
// RL2: First 64 bytes of the frame stay in the FIFO for retransmission.
// RL3: Setting transmit enable starts data requests on the buffered DMA port.
// RL4: Write side keeps filling and tells the state machine when threshold is met.
// RL5: Data is requested while the FIFO has room for one more byte.
// RL6: Transmission waits for eight bytes or a whole frame, whichever first.
// RL7: With enable and threshold, assert MII enable and send preamble plus SFD.
// RL8: Send data up to end-of-frame, then CRC unless CRC truncate is set.
// RL9: CRC covers destination address through the end of the data field.
// RL10: Short frames are zero-padded to 64 bytes unless pad suppress is set.
// RL11: Frame completion sets packet-transmitted status and interrupts if enabled.
// RL12: Fill and empty decisions use a safely transferred copy of the other counter.
// RL13: Odd parity is stored per FIFO byte and checked on readout.
// RL14: Parity error stops transmission, sets status bit, interrupts if enabled.
// RL15: Collision stops data; after preamble a 32-bit all-ones jam is sent.
// RL16: After jam wait at least 96 bit times, then resend from retained data.
// RL17: After 16 attempts set excessive-collision, interrupt, flush, ready for next frame.
// RL18: System side offers bytes on eight-bit paths; MAC answers ready; EOF marks frames.
// RL19: Transmit data goes to the PHY as nibbles timed by the MII transmit clock.
// RL20: PHY receives preamble through CRC; jam is generated here.
// RL21: PHY supplies transmit clock at 25 MHz or 2.5 MHz.
// RL22: MII enable drops right after the last CRC or jam nibble.
`timescale 1ns/100ps
`include "mtb_defs.vh"

module mtb_tx (
  input wire clock,
  input wire sys_rst,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire dma_valid,
  input wire [7:0] dma_data,
  input wire dma_eof,
  output reg dma_ready,
  output reg dma_req,
  input wire mii_tx_clk,
  input wire mii_col,
  output reg [3:0] mii_txd,
  output reg mii_tx_en,
  output reg irq
);

  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_PRE = 6'h02;
  localparam [5:0] S_DATA = 6'h04;
  localparam [5:0] S_CRC = 6'h08;
  localparam [5:0] S_JAM = 6'h10;
  localparam [5:0] S_WAIT = 6'h20;

  reg [8:0] fifo_mem [0:79]; // RL1
  reg tclk_s1_r, tclk_s2_r, tclk_s3_r;
  reg col_s1_r, col_s2_r;
  reg [5:0] ctrl_r;
  reg st_pkt_r, st_par_r, st_exc_r;
  reg [5:0] state_r;
  reg [6:0] wptr_r, rptr_r, start_r;
  reg [10:0] wr_cnt_r, rd_cnt_r, wr_copy_r, rd_copy_r, byte_cnt_r;
  reg eof_seen_r, eof_copy_r, discard_r;
  reg hi_r, pad_r, coll_pend_r;
  reg [3:0] hold_nib_r;
  reg [31:0] crc_r;
  reg [4:0] nib_r, att_r;

  function [31:0] crc_byte;
    input [31:0] c;
    input [7:0] d;
    integer i;
    reg [31:0] x;
    begin
      x = c;
      for (i = 0; i < 8; i = i + 1) begin
        if (x[0] ^ d[i])
          x = {1'b0, x[31:1]} ^ `MTB_CRC_POLY;
        else
          x = {1'b0, x[31:1]};
      end
      crc_byte = x;
    end
  endfunction

  function [6:0] ptr_inc;
    input [6:0] p;
    begin
      ptr_inc = (p == `MTB_PTR_LAST) ? 7'h00 : p + 7'h01;
    end
  endfunction

  // Falling edge of the link clock, so data is stable at the PHY's rising edge
  wire tick = tclk_s3_r & ~tclk_s2_r; // RL19
  wire take = dma_valid & dma_ready; // RL18
  wire wr_keep = take & ~discard_r;
  wire eof_take = take & dma_eof; // RL18
  // Retained window is released only once the read side is past it
  wire [10:0] rel_cnt = (rd_copy_r > `MTB_HOLD_BYTES) ? rd_copy_r : 11'h000; // RL2 RL12
  wire [10:0] used = wr_cnt_r - rel_cnt;
  wire room = (used + {10'h000, wr_keep}) < `MTB_FIFO_DEPTH; // RL5
  wire avail = rd_cnt_r != wr_copy_r; // RL12
  wire thresh_ok = (wr_copy_r >= `MTB_START_THRESH) | eof_copy_r; // RL4 RL6
  wire [8:0] rword = fifo_mem[rptr_r];
  wire par_ok = ^rword; // RL13
  // Past the retained window a retry would resend freed entries
  wire retry_ok = rd_cnt_r <= `MTB_HOLD_BYTES;
  wire need_pad = (byte_cnt_r < `MTB_MIN_DATA) & ~ctrl_r[`MTB_CTRL_PAD_SUP];
  wire [4:0] att_inc = att_r + 5'h01;
  wire acc = psel & penable;
  wire [5:0] widx = paddr[7:2];
  wire mapped = (widx == `MTB_OFS_CTRL) | (widx == `MTB_OFS_STATUS);

  // No reset on the array; an entry is always written before it is read
  always @(posedge clock) begin
    if (ce & wr_keep)
      fifo_mem[wptr_r] <= {~^dma_data, dma_data}; // RL13
  end

  // Drops the current frame and rearms the FIFO for the next one
  task frame_clear;
    begin
      wr_cnt_r <= 11'h000;
      rd_cnt_r <= 11'h000;
      wptr_r <= wptr_r;
      start_r <= wptr_r;
      rptr_r <= wptr_r;
      eof_seen_r <= 1'b0;
      att_r <= 5'h00;
      discard_r <= ~eof_seen_r & ~eof_take;
      hi_r <= 1'b0;
      pad_r <= 1'b0;
      mii_tx_en <= 1'b0; // RL22
      mii_txd <= 4'h0;
      nib_r <= 5'h00;
      state_r <= S_WAIT;
    end
  endtask

  task start_jam;
    begin
      mii_txd <= `MTB_JAM_NIB; // RL15
      nib_r <= 5'h01;
      state_r <= S_JAM;
    end
  endtask

  always @(posedge clock) begin
    if (sys_rst) begin
      tclk_s1_r <= 1'b0;
      tclk_s2_r <= 1'b0;
      tclk_s3_r <= 1'b0;
      col_s1_r <= 1'b0;
      col_s2_r <= 1'b0;
      ctrl_r <= `MTB_CTRL_RST;
      st_pkt_r <= 1'b0;
      st_par_r <= 1'b0;
      st_exc_r <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
      dma_ready <= 1'b0;
      dma_req <= 1'b0;
      mii_txd <= 4'h0;
      mii_tx_en <= 1'b0;
      state_r <= S_IDLE;
      wptr_r <= 7'h00;
      rptr_r <= 7'h00;
      start_r <= 7'h00;
      wr_cnt_r <= 11'h000;
      rd_cnt_r <= 11'h000;
      wr_copy_r <= 11'h000;
      rd_copy_r <= 11'h000;
      byte_cnt_r <= 11'h000;
      eof_seen_r <= 1'b0;
      eof_copy_r <= 1'b0;
      discard_r <= 1'b0;
      hi_r <= 1'b0;
      pad_r <= 1'b0;
      coll_pend_r <= 1'b0;
      hold_nib_r <= 4'h0;
      crc_r <= `MTB_CRC_INIT;
      nib_r <= 5'h00;
      att_r <= 5'h00;
    end else if (ce) begin
      // Three flops on the link clock and two on the collision pin from the link's clock domain
      tclk_s1_r <= mii_tx_clk;
      tclk_s2_r <= tclk_s1_r;
      tclk_s3_r <= tclk_s2_r;
      col_s1_r <= mii_col;
      col_s2_r <= col_s1_r;
      // Counter copies lag one cycle; both sides stay conservative
      wr_copy_r <= wr_cnt_r; // RL12
      rd_copy_r <= rd_cnt_r; // RL12
      eof_copy_r <= eof_seen_r;

      // Register slave, one wait state
      pready <= acc & ~pready;
      if (acc & ~pready) begin
        pslverr <= ~mapped;
        prdata <= 32'h00000000;
        if (widx == `MTB_OFS_CTRL)
          prdata <= {26'h0000000, ctrl_r};
        else if (widx == `MTB_OFS_STATUS) begin
          prdata[`MTB_ST_PKT] <= st_pkt_r;
          prdata[`MTB_ST_PAR] <= st_par_r;
          prdata[`MTB_ST_EXC] <= st_exc_r;
          prdata[`MTB_ST_ATT_LO +: 5] <= att_r;
          prdata[`MTB_ST_BUSY] <= (state_r != S_IDLE);
        end
      end
      if (acc & pready & pwrite) begin
        if (widx == `MTB_OFS_CTRL)
          ctrl_r <= pwdata[5:0];
        if (widx == `MTB_OFS_STATUS) begin
          if (pwdata[`MTB_ST_PKT])
            st_pkt_r <= 1'b0;
          if (pwdata[`MTB_ST_PAR])
            st_par_r <= 1'b0;
          if (pwdata[`MTB_ST_EXC])
            st_exc_r <= 1'b0;
        end
      end
      // Level output; a status set beats a clear in the same cycle
      irq <= (st_pkt_r & ctrl_r[`MTB_CTRL_IE_PKT]) | (st_par_r & ctrl_r[`MTB_CTRL_IE_PAR]) |
             (st_exc_r & ctrl_r[`MTB_CTRL_IE_EXC]); // RL11 RL14 RL17

      // Write side; a frame is closed to new bytes once its EOF is in
      if (take) begin
        if (!discard_r) begin
          wptr_r <= ptr_inc(wptr_r);
          wr_cnt_r <= wr_cnt_r + 11'h001;
          if (dma_eof)
            eof_seen_r <= 1'b1; // RL18
        end else if (dma_eof) begin
          discard_r <= 1'b0;
        end
      end
      // Both drop the cycle after any EOF is taken, a discarded one too
      dma_req <= ctrl_r[`MTB_CTRL_EN] & ~eof_seen_r & ~eof_take & room; // RL3 RL5
      dma_ready <= ctrl_r[`MTB_CTRL_EN] & ~eof_take & (discard_r | (~eof_seen_r & room)); // RL18

      // Link side, one nibble per transmit clock
      if (tick) begin
        case (state_r)
          S_IDLE: begin
            // Threshold is seen through the lagging copies, so a start is never early
            if (ctrl_r[`MTB_CTRL_EN] & thresh_ok) begin
              mii_tx_en <= 1'b1; // RL7
              mii_txd <= `MTB_PRE_NIB; // RL7 RL20
              nib_r <= 5'h01;
              crc_r <= `MTB_CRC_INIT;
              byte_cnt_r <= 11'h000;
              hi_r <= 1'b0;
              pad_r <= 1'b0;
              coll_pend_r <= 1'b0;
              state_r <= S_PRE;
            end
          end
          S_PRE: begin
            // A collision here is held until the preamble has gone out
            coll_pend_r <= coll_pend_r | col_s2_r; // RL15
            nib_r <= nib_r + 5'h01;
            if (nib_r == `MTB_PRE_LAST_NIB) begin
              mii_txd <= `MTB_SFD_NIB; // RL7
              state_r <= S_DATA;
            end else if (nib_r == `MTB_PRE_LAST_NIB + 5'h01) begin
              // First jam nibble follows the SFD; the jam count starts here
              mii_txd <= `MTB_JAM_NIB;
              nib_r <= 5'h01; // RL15
              state_r <= S_JAM;
            end else begin
              mii_txd <= `MTB_PRE_NIB;
            end
            if (nib_r == `MTB_PRE_LAST_NIB && !(coll_pend_r | col_s2_r))
              nib_r <= 5'h00;
            if (nib_r == `MTB_PRE_LAST_NIB && (coll_pend_r | col_s2_r))
              state_r <= S_PRE;
          end
          S_DATA: begin
            if (col_s2_r) begin
              start_jam; // RL15
            end else if (hi_r) begin
              mii_txd <= hold_nib_r; // RL19
              hi_r <= 1'b0;
            end else if (!pad_r && avail) begin
              if (!par_ok) begin
                st_par_r <= 1'b1; // RL14
                frame_clear; // RL14
              end else begin
                mii_txd <= rword[3:0]; // RL8
                hold_nib_r <= rword[7:4];
                hi_r <= 1'b1;
                crc_r <= crc_byte(crc_r, rword[7:0]); // RL9
                rptr_r <= ptr_inc(rptr_r);
                rd_cnt_r <= rd_cnt_r + 11'h001;
                byte_cnt_r <= byte_cnt_r + 11'h001;
              end
            end else if (!pad_r && !eof_copy_r) begin
              // Underrun: the frame cannot be finished, so it is dropped
              frame_clear;
            end else if (need_pad) begin
              pad_r <= 1'b1; // RL10
              mii_txd <= 4'h0; // RL10
              hold_nib_r <= 4'h0;
              hi_r <= 1'b1;
              crc_r <= crc_byte(crc_r, 8'h00); // RL9
              byte_cnt_r <= byte_cnt_r + 11'h001;
            end else if (!ctrl_r[`MTB_CTRL_CRC_TRUNC]) begin
              mii_txd <= ~crc_r[3:0]; // RL8 RL20
              crc_r <= {4'h0, crc_r[31:4]};
              nib_r <= 5'h01;
              state_r <= S_CRC;
            end else begin
              st_pkt_r <= 1'b1; // RL11
              frame_clear; // RL22
            end
          end
          S_CRC: begin
            // Inverted remainder, least significant nibble first
            if (col_s2_r) begin
              start_jam; // RL15
            end else if (nib_r == `MTB_CRC_NIBS) begin
              st_pkt_r <= 1'b1; // RL11
              frame_clear; // RL22
            end else begin
              mii_txd <= ~crc_r[3:0]; // RL8
              crc_r <= {4'h0, crc_r[31:4]};
              nib_r <= nib_r + 5'h01;
            end
          end
          S_JAM: begin
            if (nib_r == `MTB_JAM_NIBS) begin
              // Late collision: retained bytes are gone, so no retry is possible
              if (att_inc >= `MTB_MAX_ATTEMPTS || !retry_ok) begin
                st_exc_r <= 1'b1; // RL17
                frame_clear; // RL17
              end else begin
                mii_tx_en <= 1'b0; // RL22
                mii_txd <= 4'h0;
                att_r <= att_inc;
                rptr_r <= start_r; // RL2 RL16
                rd_cnt_r <= 11'h000;
                nib_r <= 5'h00;
                state_r <= S_WAIT;
              end
            end else begin
              mii_txd <= `MTB_JAM_NIB; // RL15 RL20
              nib_r <= nib_r + 5'h01;
            end
          end
          S_WAIT: begin
            // Fixed gap; no random back-off slots are added
            nib_r <= nib_r + 5'h01;
            if (nib_r == `MTB_IFG_NIBS - 5'h01) // RL16
              state_r <= S_IDLE;
          end
          default: begin
            mii_tx_en <= 1'b0;
            mii_txd <= 4'h0;
            nib_r <= 5'h00;
            state_r <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// File: shared/mtb_defs.vh
`ifndef MTB_DEFS_VH
`define MTB_DEFS_VH

// FIFO geometry
`define MTB_FIFO_DEPTH 11'h050
`define MTB_PTR_LAST 7'h4F
`define MTB_HOLD_BYTES 11'h040
`define MTB_START_THRESH 11'h008

// Frame shaping, in bytes
`define MTB_MIN_DATA 11'h03C

// Link timing, in nibbles of the transmit clock
`define MTB_PRE_LAST_NIB 5'h0F
`define MTB_JAM_NIBS 5'h08
`define MTB_CRC_NIBS 5'h08
`define MTB_IFG_NIBS 5'h18

// Link symbols
`define MTB_PRE_NIB 4'h5
`define MTB_SFD_NIB 4'hD
`define MTB_JAM_NIB 4'hF

// Retry limit
`define MTB_MAX_ATTEMPTS 5'h10

// CRC-32, reflected form
`define MTB_CRC_INIT 32'hFFFFFFFF
`define MTB_CRC_POLY 32'hEDB88320

// Register word indices, decoded from paddr[7:2]
`define MTB_OFS_CTRL 6'h00
`define MTB_OFS_STATUS 6'h01

// Control register fields
`define MTB_CTRL_EN 0
`define MTB_CTRL_CRC_TRUNC 1
`define MTB_CTRL_PAD_SUP 2
`define MTB_CTRL_IE_PKT 3
`define MTB_CTRL_IE_PAR 4
`define MTB_CTRL_IE_EXC 5
`define MTB_CTRL_RST 6'h00

// Status register fields
`define MTB_ST_PKT 0
`define MTB_ST_PAR 1
`define MTB_ST_EXC 2
`define MTB_ST_ATT_LO 8
`define MTB_ST_BUSY 13

`endif

// File: verification/mtb_tx_sva.sv
`timescale 1ns/100ps
module mtb_tx_sva (
  input wire clock,
  input wire sys_rst,
  input wire psel,
  input wire penable,
  input wire [7:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire dma_valid,
  input wire dma_eof,
  input wire dma_ready,
  input wire dma_req,
  input wire mii_tx_clk,
  input wire [3:0] mii_txd,
  input wire mii_tx_en
);
  localparam int GAP_MIN = 184;
  logic clk_q;
  logic [3:0] since_fall;
  logic [8:0] low_cnt;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Raw link clock seen here; the design adds its own sync delay
  always @(posedge clock) begin
    clk_q <= mii_tx_clk;
    if (clk_q && !mii_tx_clk)
      since_fall <= 4'h0;
    else if (since_fall != 4'hF)
      since_fall <= since_fall + 4'h1;
    if (mii_tx_en)
      low_cnt <= 9'h000;
    else if (sys_rst)
      low_cnt <= 9'h1FF;
    else if (low_cnt != 9'h1FF)
      low_cnt <= low_cnt + 9'h001;
  end
  apb_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("access phase length wrong");
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  apb_decode_a: assert property (pready |-> pslverr == (paddr[7:2] > 6'h01))
    else $error("slave error does not match address");
  eof_stop_a: assert property (dma_valid && dma_ready && dma_eof |=> !dma_ready && !dma_req)
    else $error("port still ready after end of frame");
  pre_start_a: assert property ($rose(mii_tx_en) |-> mii_txd == 4'h5)
    else $error("frame does not open with preamble");
  pre_hold_a: assert property ($rose(mii_tx_en) |-> (mii_tx_en && mii_txd == 4'h5) [*8])
    else $error("preamble nibble cut short");
  nib_timing_a: assert property ($changed(mii_txd) || $changed(mii_tx_en) |-> since_fall <= 4'h5)
    else $error("link output not tied to link clock");
  frame_gap_a: assert property ($rose(mii_tx_en) |-> low_cnt >= GAP_MIN)
    else $error("gap before transmit too short");
  cover property ($rose(mii_tx_en));
  cover property (pready && pslverr);
  cover property (dma_valid && dma_ready && dma_eof);
endmodule

bind mtb_tx mtb_tx_sva sva (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .dma_valid(dma_valid), .dma_eof(dma_eof),
  .dma_ready(dma_ready), .dma_req(dma_req), .mii_tx_clk(mii_tx_clk), .mii_txd(mii_txd),
  .mii_tx_en(mii_tx_en));

// File: verification/mtb_phy.sv
`timescale 1ns/100ps
module mtb_phy (
  output logic mii_tx_clk,
  output logic mii_col,
  input wire [3:0] mii_txd,
  input wire mii_tx_en
);
  logic col_on = 1'b0;
  logic en_q = 1'b0;
  int frames = 0;
  logic [3:0] nibs[$];
  // Transmit clock runs free, phase unrelated to the system clock
  initial begin
    mii_tx_clk = 1'b0;
    mii_col = 1'b0;
    #5;
    forever #32 mii_tx_clk = ~mii_tx_clk;
  end
  // Collision only while the MAC is sending, like a real half-duplex link
  always @(posedge mii_tx_clk) begin
    mii_col <= col_on && mii_tx_en;
    if (mii_tx_en)
      nibs.push_back(mii_txd);
    if (en_q && !mii_tx_en)
      frames++;
    en_q <= mii_tx_en;
  end
endmodule

// File: verification/mtb_tx_test.sv
`timescale 1ns/100ps
`include "mtb_defs.vh"
module mtb_tx_test;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic dma_valid = 1'b0;
  logic [7:0] dma_data = 8'h00;
  logic dma_eof = 1'b0;
  wire [31:0] prdata;
  wire [3:0] mii_txd;
  wire pready, pslverr, dma_ready, dma_req, mii_tx_clk, mii_col, mii_tx_en, irq;
  int miscompares = 0;
  int tests_run = 0;
  logic [7:0] seed = 8'h43;
  logic [31:0] rd;
  logic err;
  logic [7:0] bytes[$];
  logic [3:0] exp_q[$];
  always #4 clock = ~clock;
  mtb_tx DUT (.clock(clock), .sys_rst(sys_rst), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dma_valid(dma_valid), .dma_data(dma_data), .dma_eof(dma_eof),
    .dma_ready(dma_ready), .dma_req(dma_req), .mii_tx_clk(mii_tx_clk), .mii_col(mii_col),
    .mii_txd(mii_txd), .mii_tx_en(mii_tx_en), .irq(irq));
  mtb_phy phy (.mii_tx_clk(mii_tx_clk), .mii_col(mii_col), .mii_txd(mii_txd), .mii_tx_en(mii_tx_en));
  task results;
    if (miscompares == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task hang;
    miscompares++;
    results();
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20)
      hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bytes are held until taken; FIFO full stalls the sender here
  task send(input int len);
    int n;
    bytes = {};
    phy.nibs = {};
    repeat (len) begin
      seed = lfsr(seed);
      bytes.push_back(seed);
    end
    for (int i = 0; i < len; i++) begin
      dma_valid <= 1'b1;
      dma_data <= bytes[i];
      dma_eof <= (i == len - 1);
      n = 0;
      do begin
        @(posedge clock);
        n++;
      end while (dma_ready !== 1'b1 && n < 4000);
      if (n == 4000)
        hang();
    end
    dma_valid <= 1'b0;
  endtask
  task wait_frames(input int f);
    int n;
    n = 0;
    while (phy.frames < f && n < 30000) begin
      @(posedge clock);
      n++;
    end
    if (n == 30000)
      hang();
    repeat (200) @(posedge clock);
  endtask
  task check_frame(input logic sup, input logic crc);
    logic [31:0] c;
    logic [7:0] b;
    int len;
    exp_q = {};
    c = `MTB_CRC_INIT;
    len = (!sup && bytes.size() < `MTB_MIN_DATA) ? `MTB_MIN_DATA : bytes.size();
    repeat (15) exp_q.push_back(4'h5);
    exp_q.push_back(4'hD);
    for (int i = 0; i < len; i++) begin
      b = (i < bytes.size()) ? bytes[i] : 8'h00;
      exp_q.push_back(b[3:0]);
      exp_q.push_back(b[7:4]);
      for (int k = 0; k < 8; k++)
        c = (c >> 1) ^ ((c[0] ^ b[k]) ? `MTB_CRC_POLY : 32'h00000000);
    end
    c = ~c;
    if (crc)
      for (int k = 0; k < 8; k++)
        exp_q.push_back(c[4 * k +: 4]);
    chk(phy.nibs.size(), exp_q.size());
    for (int i = 0; i < exp_q.size() && i < phy.nibs.size(); i++)
      chk(phy.nibs[i], exp_q[i]);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    apb(0, 8'h00, 0);
    chk(rd, 0);
    apb(0, 8'h08, 0);
    chk({rd[30:0], err}, 1);
    apb(1, 8'h00, 32'h00000029);
    send(100);
    wait_frames(1);
    check_frame(0, 1);
    apb(0, 8'h04, 0);
    chk({irq, rd[2:0]}, 4'h9);
    apb(1, 8'h04, 32'h00000007);
    apb(0, 8'h04, 0);
    chk({irq, rd[2:0]}, 4'h0);
    apb(1, 8'h00, 32'h00000007);
    send(5);
    wait_frames(2);
    check_frame(1, 0);
    apb(1, 8'h00, 32'h00000029);
    phy.col_on <= 1'b1;
    send(20);
    wait_frames(18);
    chk(phy.nibs.size(), 384);
    for (int i = 16; i < 24; i++)
      chk(phy.nibs[i], 4'hF);
    apb(0, 8'h04, 0);
    chk({irq, rd[2]}, 2'h3);
    phy.col_on <= 1'b0;
    apb(1, 8'h04, 32'h00000007);
    send(12);
    wait_frames(19);
    check_frame(0, 1);
    results();
  end
endmodule
